// File: hdl/ssx_pkg.sv
// Constants for the store and sign-extend execution unit
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// [RQ1] Byte store with immediate: address is base plus immediate, low byte written.
// [RQ2] Virtual mode and no translation: cause 10010, store flag set.
// [RQ3] Virtual mode and protection refusal: cause 10000, store flag, no-access flag recorded.
// [RQ4] No-access refusal only counts in user mode; privileged sees read-only only.
// [RQ5] Miss or storage fault saves user and virtual mode bits, then clears both.
// [RQ6] Priority: miss, then protection, then alignment; write only when none applies.
// [RQ7] Odd halfword address: cause 00001, word flag 0, store flag, source number recorded.
// [RQ8] Register halfword store: address is sum of both bases, low halfword written.
// [RQ9] Halfword store with immediate: base plus immediate, low halfword written.
// [RQ10] Reverse bit on a halfword store swaps its two bytes.
// [RQ11] Reversed store forms work only when the reorder parameter is 1.
// [RQ12] Stores take 1 cycle without area optimisation, 2 cycles with it.
// [RQ13] Immediate is sign-extended 16 bits, or full 32 bits after a prefix.
// [RQ14] Halfword extend copies source bit 15 into bits 31 to 16, one cycle.
// [RQ15] Byte extend copies source bit 7 into bits 31 to 8, one cycle.
// [RQ16] Word flag and source number change only on an alignment fault.
// [RQ17] A faulting store asserts no byte enable and no write.
package ssx_pkg;

    //------------------------------------------------------------
    // Operations
    //------------------------------------------------------------
    localparam logic [2:0] OP_STB_REG  = 3'h0;
    localparam logic [2:0] OP_STB_IMM  = 3'h1;
    localparam logic [2:0] OP_STH_REG  = 3'h2;
    localparam logic [2:0] OP_STH_IMM  = 3'h3;
    localparam logic [2:0] OP_EXT_HALF = 3'h4;
    localparam logic [2:0] OP_EXT_BYTE = 3'h5;

    //------------------------------------------------------------
    // Register offsets
    //------------------------------------------------------------
    localparam logic [7:0] OFS_MACH_STATUS = 8'h00;
    localparam logic [7:0] OFS_EXC_STATUS  = 8'h04;
    localparam logic [7:0] OFS_EVT_STATUS  = 8'h08;
    localparam logic [7:0] OFS_EVT_MASK    = 8'h0C;

    //------------------------------------------------------------
    // Field positions
    //------------------------------------------------------------
    localparam int POS_USER_MODE  = 0;
    localparam int POS_VIRT_MODE  = 1;
    localparam int POS_SAVED_USER = 2;
    localparam int POS_SAVED_VIRT = 3;
    localparam int POS_CAUSE_LO   = 0;
    localparam int POS_STORE_FLAG = 5;
    localparam int POS_WORD_FLAG  = 6;
    localparam int POS_NO_ACCESS  = 7;
    localparam int POS_SRC_LO     = 8;
    localparam int POS_EVT_MISS   = 0;
    localparam int POS_EVT_PROT   = 1;
    localparam int POS_EVT_ALIGN  = 2;
    localparam int POS_EVT_DONE   = 3;
    localparam int EVT_W          = 4;

    //------------------------------------------------------------
    // Cause codes and reset values
    //------------------------------------------------------------
    localparam logic [4:0]       CAUSE_MISS  = 5'h12;
    localparam logic [4:0]       CAUSE_PROT  = 5'h10;
    localparam logic [4:0]       CAUSE_ALIGN = 5'h01;
    localparam logic [3:0]       MODE_RST    = 4'h0;
    localparam logic [EVT_W-1:0] MASK_RST    = 4'h0;

    //------------------------------------------------------------
    // Store latency in cycles
    //------------------------------------------------------------
    localparam int LAT_FAST_CYC = 1;
    localparam int LAT_AREA_CYC = 2;

endpackage : ssx_pkg

// File: hdl/ssx_lane_pack.sv
// Byte lane placement for stores and the two sign extensions
`timescale 1ns/1ps
`default_nettype none

module ssx_lane_pack (
    input  wire logic        is_half,
    input  wire logic        reverse,
    input  wire logic [1:0]  addr_lo,
    input  wire logic [31:0] src,
    output logic      [31:0] wdata,
    output logic      [3:0]  be,
    output logic      [31:0] ext_half,
    output logic      [31:0] ext_byte
);

    //------------------------------------------------------------
    // Lanes are big-endian: offset 0 lands in bits 31 to 24
    //------------------------------------------------------------
    wire logic [1:0]  byte_ofs;
    wire logic        half_hi;
    wire logic [15:0] half_val;

    assign byte_ofs = reverse ? ~addr_lo : addr_lo;                   // see [RQ11]
    assign half_hi  = reverse ? addr_lo[1] : ~addr_lo[1];
    assign half_val = reverse ? {src[7:0], src[15:8]} : src[15:0];    // see [RQ10]

    assign wdata = is_half ? {2{half_val}} : {4{src[7:0]}};           // see [RQ1] see [RQ8]
    assign be    = is_half ? (half_hi ? 4'hC : 4'h3) : (4'h8 >> byte_ofs);

    assign ext_half = {{16{src[15]}}, src[15:0]};                     // see [RQ14]
    assign ext_byte = {{24{src[7]}}, src[7:0]};                       // see [RQ15]

endmodule : ssx_lane_pack

`default_nettype wire

// File: hdl/ssx_store_unit.sv
// Store and sign-extend execution unit with fault checks and registers
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module ssx_store_unit #(
    parameter int AREA_OPTIMIZE_PARAM = 0,
    parameter int REORDER_INSTR_PARAM = 1
) (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        op_valid,
    input  wire logic [2:0]  op_code,
    input  wire logic        op_reverse,
    input  wire logic [31:0] base_reg_a,
    input  wire logic [31:0] base_reg_b,
    input  wire logic [15:0] op_imm,
    input  wire logic        imm_prefix_valid,
    input  wire logic [15:0] imm_prefix_hi,
    input  wire logic [31:0] op_src,
    input  wire logic [4:0]  op_src_num,
    output logic             op_ready,
    output logic [31:0]      mmu_addr,
    input  wire logic        mmu_miss,
    input  wire logic        mmu_read_only,
    input  wire logic        mmu_no_access,
    output logic             mem_wr,
    output logic [31:0]      mem_addr,
    output logic [3:0]       mem_be,
    output logic [31:0]      mem_wdata,
    output logic [31:0]      result,
    output logic             result_we,
    output logic             done,
    output logic             exc_raise,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic             irq
);

    //------------------------------------------------------------
    // Configuration checks
    //------------------------------------------------------------
    if (AREA_OPTIMIZE_PARAM < 0 || AREA_OPTIMIZE_PARAM > 1) begin : g_bad_area
        $error("area optimize parameter must be 0 or 1");
    end
    if (REORDER_INSTR_PARAM < 0 || REORDER_INSTR_PARAM > 1) begin : g_bad_reorder
        $error("reorder parameter must be 0 or 1");
    end

    localparam int LAT = AREA_OPTIMIZE_PARAM == 1 ? ssx_pkg::LAT_AREA_CYC : ssx_pkg::LAT_FAST_CYC;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_EVAL} ssx_state_t;

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    ssx_state_t  state_r;
    ssx_state_t  state_nxt;
    logic        is_half_r;
    logic        rev_r;
    logic [31:0] src_r;
    logic [4:0]  src_num_r;
    logic [31:0] addr_r;
    logic        op_ready_r;
    logic        mem_wr_r;
    logic [31:0] mem_addr_r;
    logic [3:0]  mem_be_r;
    logic [31:0] mem_wdata_r;
    logic [31:0] result_r;
    logic        result_we_r, done_r, exc_raise_r;
    logic        user_mode_bit_r, virt_mode_bit_r, saved_user_mode_bit_r, saved_virtual_mode_bit_r;
    logic [4:0]  exception_cause_code_r;
    logic        exc_store_r, exc_word_r, no_access_zone_flag_r;
    logic [4:0]  exc_src_r;
    logic [ssx_pkg::EVT_W-1:0] evt_r;
    logic [ssx_pkg::EVT_W-1:0] mask_r;
    logic [31:0] reg_rdata_r;
    logic        irq_r;

    //------------------------------------------------------------
    // Decode and effective address
    //------------------------------------------------------------
    wire logic        op_take, op_is_ext, op_is_imm, op_is_half;
    wire logic [31:0] imm_val;
    wire logic [31:0] eff_addr;

    assign op_take    = op_valid && op_ready_r;
    assign op_is_ext  = op_code == ssx_pkg::OP_EXT_HALF || op_code == ssx_pkg::OP_EXT_BYTE;
    assign op_is_imm  = op_code == ssx_pkg::OP_STB_IMM || op_code == ssx_pkg::OP_STH_IMM;
    assign op_is_half = op_code == ssx_pkg::OP_STH_REG || op_code == ssx_pkg::OP_STH_IMM;
    assign imm_val    = imm_prefix_valid ? {imm_prefix_hi, op_imm}
                                         : {{16{op_imm[15]}}, op_imm};           // see [RQ13]
    assign eff_addr   = base_reg_a + (op_is_imm ? imm_val : base_reg_b);   // see [RQ1] see [RQ8] see [RQ9]

    //------------------------------------------------------------
    // Fault checks, in priority order
    //------------------------------------------------------------
    wire logic commit, miss_hit, no_access_hit, prot_hit, align_hit, mode_fault, fault;

    assign commit        = state_r == ST_EVAL;
    assign miss_hit      = virt_mode_bit_r && mmu_miss;                           // see [RQ2]
    assign no_access_hit = mmu_no_access && user_mode_bit_r;                      // see [RQ4]
    assign prot_hit      = virt_mode_bit_r && !mmu_miss
                           && (mmu_read_only || no_access_hit);                   // see [RQ3] see [RQ6]
    assign align_hit     = !miss_hit && !prot_hit && is_half_r && addr_r[0];      // see [RQ6] see [RQ7]
    assign mode_fault    = miss_hit || prot_hit;
    assign fault         = mode_fault || align_hit;

    //------------------------------------------------------------
    // Lanes and extension
    //------------------------------------------------------------
    wire logic [31:0] lane_wdata, ext_half, ext_byte;
    wire logic [3:0]  lane_be;

    ssx_lane_pack u_lane (
        .is_half  (is_half_r),
        .reverse  (rev_r),
        .addr_lo  (addr_r[1:0]),
        .src      (commit ? src_r : op_src),
        .wdata    (lane_wdata),
        .be       (lane_be),
        .ext_half (ext_half),
        .ext_byte (ext_byte)
    );

    //------------------------------------------------------------
    // Sequencer
    //------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (op_take && !op_is_ext) begin
                    state_nxt = LAT > 1 ? ST_WAIT : ST_EVAL;                 // see [RQ12]
                end
            end
            ST_WAIT: begin
                state_nxt = ST_EVAL;
            end
            ST_EVAL: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_r    <= ST_IDLE;
            op_ready_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            op_ready_r <= state_nxt == ST_IDLE;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            is_half_r <= 1'b0;
            rev_r     <= 1'b0;
            src_r     <= 32'h0000_0000;
            src_num_r <= 5'h00;
            addr_r    <= 32'h0000_0000;
        end else if (op_take && !op_is_ext) begin
            is_half_r <= op_is_half;
            // Immediate forms carry no reverse bit
            rev_r     <= op_reverse && !op_is_imm && REORDER_INSTR_PARAM == 1;   // see [RQ11]
            src_r     <= op_src;
            src_num_r <= op_src_num;
            addr_r    <= eff_addr;
        end
    end

    //------------------------------------------------------------
    // Memory write and results
    //------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mem_wr_r    <= 1'b0;
            mem_addr_r  <= 32'h0000_0000;
            mem_be_r    <= 4'h0;
            mem_wdata_r <= 32'h0000_0000;
        end else begin
            mem_wr_r <= commit && !fault;                                    // see [RQ6] see [RQ17]
            mem_be_r <= commit && !fault ? lane_be : 4'h0;                   // see [RQ17]
            if (commit) begin
                mem_addr_r  <= {addr_r[31:2], 2'b00};
                mem_wdata_r <= lane_wdata;
            end
        end
    end

    // Extends finish in the take cycle, so they never see the store stage busy
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            result_r    <= 32'h0000_0000;
            result_we_r <= 1'b0;
            done_r      <= 1'b0;
            exc_raise_r <= 1'b0;
        end else begin
            result_we_r <= op_take && op_is_ext;
            done_r      <= (op_take && op_is_ext) || commit;                // see [RQ12]
            exc_raise_r <= commit && fault;
            if (op_take && op_is_ext) begin
                result_r <= op_code == ssx_pkg::OP_EXT_HALF ? ext_half : ext_byte;  // see [RQ14] see [RQ15]
            end
        end
    end

    //------------------------------------------------------------
    // Mode bits and exception status
    //------------------------------------------------------------
    wire logic wr_mach, wr_evt, wr_mask;

    assign wr_mach = reg_wr && reg_addr == ssx_pkg::OFS_MACH_STATUS;
    assign wr_evt  = reg_wr && reg_addr == ssx_pkg::OFS_EVT_STATUS;
    assign wr_mask = reg_wr && reg_addr == ssx_pkg::OFS_EVT_MASK;

    // A miss or protection fault in the same cycle as a software write wins
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            user_mode_bit_r          <= ssx_pkg::MODE_RST[ssx_pkg::POS_USER_MODE];
            virt_mode_bit_r          <= ssx_pkg::MODE_RST[ssx_pkg::POS_VIRT_MODE];
            saved_user_mode_bit_r    <= ssx_pkg::MODE_RST[ssx_pkg::POS_SAVED_USER];
            saved_virtual_mode_bit_r <= ssx_pkg::MODE_RST[ssx_pkg::POS_SAVED_VIRT];
        end else if (commit && mode_fault) begin
            saved_user_mode_bit_r    <= user_mode_bit_r;                     // see [RQ5]
            saved_virtual_mode_bit_r <= virt_mode_bit_r;                     // see [RQ5]
            user_mode_bit_r          <= 1'b0;
            virt_mode_bit_r          <= 1'b0;
        end else if (wr_mach) begin
            user_mode_bit_r          <= reg_wdata[ssx_pkg::POS_USER_MODE];
            virt_mode_bit_r          <= reg_wdata[ssx_pkg::POS_VIRT_MODE];
            saved_user_mode_bit_r    <= reg_wdata[ssx_pkg::POS_SAVED_USER];
            saved_virtual_mode_bit_r <= reg_wdata[ssx_pkg::POS_SAVED_VIRT];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            exception_cause_code_r <= 5'h00;
            exc_store_r            <= 1'b0;
            exc_word_r             <= 1'b0;
            no_access_zone_flag_r  <= 1'b0;
            exc_src_r              <= 5'h00;
        end else if (commit && fault) begin
            exc_store_r <= 1'b1;
            if (miss_hit) begin
                exception_cause_code_r <= ssx_pkg::CAUSE_MISS;               // see [RQ2]
            end else if (prot_hit) begin
                exception_cause_code_r <= ssx_pkg::CAUSE_PROT;               // see [RQ3]
                no_access_zone_flag_r  <= no_access_hit;                     // see [RQ4]
            end else begin
                exception_cause_code_r <= ssx_pkg::CAUSE_ALIGN;              // see [RQ7]
                exc_word_r             <= 1'b0;                              // see [RQ16]
                exc_src_r              <= src_num_r;                         // see [RQ16]
            end
        end
    end

    //------------------------------------------------------------
    // Event status, mask and interrupt
    //------------------------------------------------------------
    wire logic [ssx_pkg::EVT_W-1:0] evt_set, evt_nxt, mask_nxt;

    assign evt_set  = commit ? {!fault, align_hit, prot_hit, miss_hit} : 4'h0;
    // Set beats a write-one clear so no event is lost
    assign evt_nxt  = (evt_r & ~(wr_evt ? reg_wdata[ssx_pkg::EVT_W-1:0] : 4'h0)) | evt_set;
    assign mask_nxt = wr_mask ? reg_wdata[ssx_pkg::EVT_W-1:0] : mask_r;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            evt_r  <= 4'h0;
            mask_r <= ssx_pkg::MASK_RST;
            irq_r  <= 1'b0;
        end else begin
            evt_r  <= evt_nxt;
            mask_r <= mask_nxt;
            irq_r  <= |(evt_nxt & mask_nxt);
        end
    end

    //------------------------------------------------------------
    // Register read
    //------------------------------------------------------------
    wire logic [31:0] rd_mux;

    assign rd_mux = reg_addr == ssx_pkg::OFS_MACH_STATUS ?
                        {28'h000_0000, saved_virtual_mode_bit_r, saved_user_mode_bit_r,
                         virt_mode_bit_r, user_mode_bit_r} :
                    reg_addr == ssx_pkg::OFS_EXC_STATUS ?
                        {19'h0_0000, exc_src_r, no_access_zone_flag_r, exc_word_r,
                         exc_store_r, exception_cause_code_r} :
                    reg_addr == ssx_pkg::OFS_EVT_STATUS ? {28'h000_0000, evt_r} :
                    reg_addr == ssx_pkg::OFS_EVT_MASK   ? {28'h000_0000, mask_r} :
                    32'h0000_0000;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_r <= 32'h0000_0000;
        end else begin
            reg_rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    assign op_ready  = op_ready_r;
    assign mmu_addr  = addr_r;
    assign mem_wr    = mem_wr_r;
    assign mem_addr  = mem_addr_r;
    assign mem_be    = mem_be_r;
    assign mem_wdata = mem_wdata_r;
    assign result    = result_r;
    assign result_we = result_we_r;
    assign done      = done_r;
    assign exc_raise = exc_raise_r;
    assign reg_rdata = reg_rdata_r;
    assign irq       = irq_r;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    a_byte_write: assert property (@(posedge ref_clk) disable iff (!nrst)   // see [RQ1]
        commit && !fault && !is_half_r |=> mem_wr_r && $countones(mem_be_r) == 1)
        else $error("byte store did not write one lane");
    a_miss_cause: assert property (@(posedge ref_clk) disable iff (!nrst)   // see [RQ2]
        commit && miss_hit |=> exception_cause_code_r == ssx_pkg::CAUSE_MISS && exc_store_r && !mem_wr_r)
        else $error("translation miss not recorded");
    a_prot_cause: assert property (@(posedge ref_clk) disable iff (!nrst)   // see [RQ3]
        commit && prot_hit |=> exception_cause_code_r == ssx_pkg::CAUSE_PROT && exc_raise_r
            && mem_be_r == 4'h0)
        else $error("storage fault not recorded");
    a_priv_no_zone: assert property (@(posedge ref_clk) disable iff (!nrst) // see [RQ4]
        commit && prot_hit && !user_mode_bit_r |=> !no_access_zone_flag_r)
        else $error("no-access flag set in privileged mode");
    a_mode_save: assert property (@(posedge ref_clk) disable iff (!nrst)    // see [RQ5]
        commit && mode_fault |=> !user_mode_bit_r && !virt_mode_bit_r
            && saved_user_mode_bit_r == $past(user_mode_bit_r)
            && saved_virtual_mode_bit_r == $past(virt_mode_bit_r))
        else $error("mode bits not saved and cleared");
    a_align_fault: assert property (@(posedge ref_clk) disable iff (!nrst)  // see [RQ7]
        commit && align_hit |=> exception_cause_code_r == ssx_pkg::CAUSE_ALIGN && !exc_word_r
            && exc_src_r == $past(src_num_r) && !mem_wr_r)
        else $error("alignment fault not recorded");
    a_half_write: assert property (@(posedge ref_clk) disable iff (!nrst)   // see [RQ8]
        commit && !fault && is_half_r |=> mem_wr_r && $countones(mem_be_r) == 2)
        else $error("halfword store did not write two lanes");
    a_store_lat: assert property (@(posedge ref_clk) disable iff (!nrst)     // see [RQ12]
        op_take && !op_is_ext |-> ##LAT !op_ready_r ##1 done_r && op_ready_r)
        else $error("store latency wrong");
    a_ext_sign: assert property (@(posedge ref_clk) disable iff (!nrst)     // see [RQ14]
        op_take && op_code == ssx_pkg::OP_EXT_HALF |=> result_we_r
            && result_r == {{16{$past(op_src[15])}}, $past(op_src[15:0])})
        else $error("halfword extend wrong");
    a_src_keep: assert property (@(posedge ref_clk) disable iff (!nrst)     // see [RQ16]
        commit && mode_fault |=> $stable(exc_src_r) && $stable(exc_word_r))
        else $error("source field changed on non-alignment fault");

endmodule : ssx_store_unit

`default_nettype wire

// File: hdl/ssx_unused_guard.sv
// Spare source file that holds no logic

// File: tb/ssx_mmu_model.sv
// Translation responder facing the store unit
`timescale 1ns/1ps
`default_nettype none
module ssx_mmu_model (
    input  wire logic [31:0] addr,
    input  wire logic [2:0]  fault,
    output logic             miss,
    output logic             read_only,
    output logic             no_access
);
    // Low page always translates, so stores there never see a miss or protection fault
    assign {no_access, read_only, miss} = fault & {3{addr[31:8] != '0}};
endmodule : ssx_mmu_model
`default_nettype wire

// File: tb/ssx_store_unit_test.sv
// Self-checking bench of the store and sign-extend unit
`timescale 1ns/1ps
`default_nettype none
module ssx_store_unit_test;
    logic        ref_clk, nrst, op_valid, pv, reg_wr, reg_rd, miss, ro, na, mem_wr, exc_raise, irq, rv, rev;
    logic        rdy, dn, rwe;
    logic [2:0]  op_code, fault;
    logic [3:0]  mem_be;
    logic [7:0]  reg_addr;
    logic [15:0] im, hi;
    logic [31:0] a, b, s, r, d, ea, mmu_addr, mem_addr, mem_wdata, result, reg_wdata, reg_rdata;
    int          error_cnt, n_checks, cyc, i;
    wire logic [68:0] st = {mem_wr, mem_addr, mem_be, mem_wdata};
    ssx_store_unit DUT (.ref_clk(ref_clk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code), .op_reverse(rv),
        .base_reg_a(a), .base_reg_b(b), .op_imm(im), .imm_prefix_valid(pv), .imm_prefix_hi(hi), .op_src(s),
        .op_src_num(5'h0b), .op_ready(rdy), .mmu_addr(mmu_addr), .mmu_miss(miss), .mmu_read_only(ro),
        .mmu_no_access(na), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata),
        .result(result), .result_we(rwe), .done(dn), .exc_raise(exc_raise), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    ssx_mmu_model MMU (.addr(mmu_addr), .fault(fault), .miss(miss), .read_only(ro), .no_access(na));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // Reversed forms mirror the lane and swap the halfword's bytes
    function automatic logic [68:0] st_exp(input logic h);
        logic [3:0]  be;
        logic [31:0] w;
        be = h ? ((ea[1] ^ rev) ? 4'h3 : 4'hc) : (rev ? 4'h1 << ea[1:0] : 4'h8 >> ea[1:0]);
        w  = !h ? {4{s[7:0]}} : (rev ? {2{s[7:0], s[15:8]}} : {2{s[15:0]}});
        return {1'b1, ea & ~32'h3, be, w};
    endfunction : st_exp
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("mismatch %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk
    // Stores wait one more edge than extends before the outputs are looked at
    task automatic go(input logic [2:0] c);
        @(posedge ref_clk);
        {op_valid, op_code} <= {1'b1, c};
        @(posedge ref_clk);
        op_valid <= 1'b0;
        #1;
        chk(rdy, c[2]);
        repeat (c[2] ? 0 : 1) @(posedge ref_clk);
        #1;
        chk({dn, rwe}, {1'b1, c[2]});
        ea = a + (c[0] ? (pv ? {hi, im} : {{16{im[15]}}, im}) : b);
        rev = rv && !c[0];
    endtask : go
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] v);
        @(posedge ref_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, ad, v};
        @(posedge ref_clk);
        {reg_wr, reg_rd} <= 2'b0;
        #1;
        d = reg_rdata;
    endtask : bus
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            stop_test;
        end
    end
    initial begin
        {nrst, op_valid, pv, rv, reg_wr, reg_rd, op_code, fault, reg_addr, im, hi, a, b, s, reg_wdata} = '0;
        r = 32'h25c0;
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        bus(1'b0, 8'h0c, '0);
        chk(d, '0);
        for (i = 0; i < 60; i++) begin
            r = lfsr(r);
            @(posedge ref_clk);
            {s, im, hi, pv, rv} <= {r, r[31:17], 1'b0, r[15:0], r[4], r[5]};
            a <= lfsr(r) & ~32'h1;
            b <= r & 32'h7ffe;
            go(3'(i % 6));
            case (i % 6)
                0, 1: chk(st, st_exp(1'b0));
                2, 3: chk(st, st_exp(1'b1));
                4: chk(result, {{16{s[15]}}, s[15:0]});
                default: chk(result, {{24{s[7]}}, s[7:0]});
            endcase
        end
        @(posedge ref_clk);
        {a, b, rv} <= {32'h1, 32'h0, 1'b0};
        go(ssx_pkg::OP_STH_REG);
        chk({exc_raise, mem_wr, mem_be}, 6'h20);
        bus(1'b0, 8'h04, '0);
        chk(d[12:0], 13'h0b21);
        @(posedge ref_clk);
        {a, fault} <= {32'h100, 3'h3};
        bus(1'b1, 8'h00, 32'h3);
        go(ssx_pkg::OP_STB_REG);
        chk({exc_raise, mem_wr}, 2'h2);
        bus(1'b0, 8'h00, '0);
        chk(d[3:0], 4'hc);
        bus(1'b0, 8'h04, '0);
        chk(d[12:0], 13'h0b32);
        @(posedge ref_clk);
        fault <= 3'h4;
        bus(1'b1, 8'h00, 32'h3);
        go(ssx_pkg::OP_STB_REG);
        bus(1'b0, 8'h04, '0);
        chk(d[12:0], 13'h0bb0);
        bus(1'b1, 8'h00, 32'h2);
        go(ssx_pkg::OP_STB_REG);
        chk({exc_raise, mem_wr}, 2'h1);
        chk(irq, 1'b0);
        bus(1'b1, 8'h0c, 32'h4);
        bus(1'b0, 8'h40, '0);
        chk({irq, d}, {1'b1, 32'h0});
        bus(1'b1, 8'h08, 32'hf);
        bus(1'b0, 8'h08, '0);
        chk({irq, d}, '0);
        stop_test;
    end
endmodule : ssx_store_unit_test
`default_nettype wire
